// ===== core/mps_pkg.sv
// Function
// RL1 - clock split into four phases per cycle
// RL2 - counter advances at phase one, fetch there
// RL3 - fetch overlaps execute, one per cycle
// RL4 - jump and call take two cycles
// RL5 - taken skip replaces prefetch with dummy
// RL6 - counter increments unless control transfers
// RL7 - counter width follows program memory size
// RL8 - jumps, calls, interrupts, reset load target
// RL9 - low byte writable, page jump, dummy cycle
// RL10 - stack hidden, holds counter values only
// RL11 - call/interrupt push, returns pop the stack
// RL12 - reset points stack pointer at top
// RL13 - full stack holds interrupt until return
// RL14 - call on full stack overflows unprotected
// RL15 - result to destination, flags updated
// RL16 - add, subtract, carry forms, decimal adjust
// RL17 - and, or, xor, complement operations
// RL18 - rotations with and without carry
// RL19 - increment and decrement memory operand
// RL20 - jump, skips, call, return decisions
// RL21 - eight bit datapath through accumulator
// RL22 - stack depth two or four, full flag
package mps_pkg;

  // program counter width: 10, 11 or 12 bits for 1K, 2K, 4K words
  localparam int PC_W        = 12;                          // [RL7]
  localparam int IW          = 16;
  localparam int DW          = 8;
  localparam int DMEM_N      = 16;
  localparam int DMEM_AW     = 4;
  localparam int PAGE_LSB    = 8;

  localparam logic [PC_W-1:0] RESET_VEC = 12'h000;
  localparam logic [PC_W-1:0] INT_VEC   = 12'h004;

  typedef enum logic [3:0] {
    PH_T1 = 4'h1,
    PH_T2 = 4'h2,
    PH_T3 = 4'h4,
    PH_T4 = 4'h8
  } mps_phase_t;

  // instruction word layout
  localparam int OPC_HI  = 15;
  localparam int OPC_LO  = 11;
  localparam int DST_BIT = 10;
  localparam int TGT_HI  = 10;
  localparam int MA_HI   = 3;
  localparam int IMM_HI  = 7;

  typedef enum logic [4:0] {
    OP_NOP  = 5'h00, OP_ADD  = 5'h01, OP_ADC  = 5'h02, OP_SUB  = 5'h03,
    OP_SBC  = 5'h04, OP_DADJ = 5'h05, OP_AND  = 5'h06, OP_OR   = 5'h07,
    OP_XOR  = 5'h08, OP_CMPL = 5'h09, OP_RR   = 5'h0A, OP_RRC  = 5'h0B,
    OP_RL   = 5'h0C, OP_RLC  = 5'h0D, OP_INC  = 5'h0E, OP_DEC  = 5'h0F,
    OP_SZ   = 5'h10, OP_SNZ  = 5'h11, OP_SIZ  = 5'h12, OP_SDZ  = 5'h13,
    OP_JMP  = 5'h14, OP_CALL = 5'h15, OP_RET  = 5'h16, OP_RETURN_FROM_INTERRUPT = 5'h17,
    OP_MOV  = 5'h18, OP_MOVI = 5'h19
  } mps_op_t;

  localparam logic [IW-1:0] NOP_WORD = 16'h0000;
  localparam logic [3:0] MA_PC_LOW   = 4'h0;

  // register map, word indexes; byte address is four times
  localparam logic [1:0] REG_CTRL  = 2'h0;
  localparam logic [1:0] REG_PEND  = 2'h1;
  localparam logic [1:0] REG_STATE = 2'h2;
  localparam logic [1:0] REG_ACC   = 2'h3;
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_IE   = 1;
  localparam int ST_SP_LO  = 12;
  localparam int ST_FULL   = 15;
  localparam int ST_C      = 16;
  localparam int ST_Z      = 17;
  localparam int ST_AC     = 18;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  localparam logic [7:0] BCD_LO  = 8'h06;
  localparam logic [7:0] BCD_HI  = 8'h60;
  localparam logic [3:0] BCD_MAX = 4'h9;

endpackage

// ===== core/mps_core.sv
`timescale 1ns/1ps
module mps_core #(
  parameter int STACK_DEPTH = 4
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output      logic [31:0]              hrdata,
  output      logic                     hreadyout,
  output      logic                     hresp,
  output      logic [mps_pkg::PC_W-1:0] pmem_addr,
  input  wire logic [mps_pkg::IW-1:0]   pmem_data,
  input  wire logic                     irq_req,
  output      logic                     int_ack,
  output      logic                     cycle_start
);
  import mps_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH) + 1;
  localparam int SI_W = SP_W - 1;
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);
  localparam logic [SP_W-1:0] SP_ONE  = SP_W'(1);
  localparam logic [PC_W-1:0] PC_ONE  = PC_W'(1);

  //////////////////////////////////////////////////////////////////////////
  mps_phase_t       phase_reg;
  mps_phase_t       phase_next;
  logic [PC_W-1:0]  pc_reg;
  logic [PC_W-1:0]  pc_next;
  logic [PC_W-1:0]  pmem_addr_reg;
  logic [IW-1:0]    fetch_reg;
  logic [IW-1:0]    ir_reg;
  logic [DW-1:0]    acc_reg;
  logic             c_reg;
  logic             z_reg;
  logic             ac_reg;
  logic [DW-1:0]    dmem_reg [DMEM_N];
  logic [PC_W-1:0]  stack_reg [STACK_DEPTH];
  logic [SP_W-1:0]  sp_reg;
  logic [SP_W-1:0]  sp_next;
  logic             run_reg;
  logic             ie_reg;
  logic             pend_reg;
  logic             ack_reg;
  logic             ap_valid_reg;
  logic             ap_wr_reg;
  logic [1:0]       ap_idx_reg;
  logic [31:0]      hrdata_reg;
  logic             hreadyout_reg;
  logic             hresp_reg;

  function automatic logic [DW+1:0] alu_add(input logic [DW-1:0] a,
                                            input logic [DW-1:0] b,
                                            input logic          cin);
    logic [4:0]    lo;
    logic [DW:0]   s;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    s  = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, cin};
    return {lo[4], s};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // decode of the executing word
  wire mps_op_t          opc     = mps_op_t'(ir_reg[OPC_HI:OPC_LO]);
  wire                   to_mem  = ir_reg[DST_BIT];
  wire [DMEM_AW-1:0]     ma      = ir_reg[MA_HI:0];
  wire [DW-1:0]          imm     = ir_reg[IMM_HI:0];
  wire [DW-1:0]          mval    = (ma == MA_PC_LOW) ? pmem_addr_reg[DW-1:0] : dmem_reg[ma];
  wire [PC_W-1:0]        jtgt    = {pc_reg[PC_W-1:TGT_HI+1], ir_reg[TGT_HI:0]};
  wire                   ex_go   = run_reg && (phase_reg == PH_T4);
  wire                   full    = (sp_reg == SP_FULL);   // [RL22]
  wire [SI_W-1:0]        push_ix = sp_reg[SI_W-1:0];
  wire [SI_W-1:0]        pop_ix  = push_ix - SI_W'(1);
  wire [PC_W-1:0]        stk_top = stack_reg[pop_ix];

  logic [DW-1:0] res;
  logic          c_n;
  logic          ac_n;
  logic          wr_acc;
  logic          wr_mem;
  logic          upd_z;
  logic          skip;
  logic [DW+1:0] sum;
  logic [DW:0]   da_t;
  logic          da_hi;

  always_comb begin
    res    = acc_reg;
    c_n    = c_reg;
    ac_n   = ac_reg;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_z  = 1'b0;
    skip   = 1'b0;
    sum    = '0;
    da_t   = '0;
    da_hi  = 1'b0;
    case (opc)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        // subtract as a + ~b + 1; carry high means no borrow
        case (opc)
          OP_ADD:  sum = alu_add(acc_reg, mval, 1'b0);
          OP_ADC:  sum = alu_add(acc_reg, mval, c_reg);
          OP_SUB:  sum = alu_add(acc_reg, ~mval, 1'b1);
          default: sum = alu_add(acc_reg, ~mval, c_reg);
        endcase
        res   = sum[DW-1:0];                                    // [RL16]
        c_n   = sum[DW];                                        // [RL15]
        ac_n  = sum[DW+1];
        upd_z = 1'b1;
        wr_acc = !to_mem;
        wr_mem = to_mem;
      end
      OP_DADJ: begin
        da_t  = {1'b0, acc_reg} + (((acc_reg[3:0] > BCD_MAX) || ac_reg) ? BCD_LO : '0);
        da_hi = da_t[DW] || (da_t[DW-1:4] > BCD_MAX) || c_reg;
        res   = da_t[DW-1:0] + (da_hi ? BCD_HI : '0);           // [RL16]
        c_n   = da_hi;
        wr_acc = 1'b1;
      end
      OP_AND, OP_OR, OP_XOR, OP_CMPL: begin
        case (opc)
          OP_AND:  res = acc_reg & mval;                        // [RL17]
          OP_OR:   res = acc_reg | mval;
          OP_XOR:  res = acc_reg ^ mval;
          default: res = ~mval;
        endcase
        upd_z  = 1'b1;
        wr_acc = !to_mem;
        wr_mem = to_mem;
      end
      OP_RR, OP_RRC, OP_RL, OP_RLC: begin
        case (opc)
          OP_RR:   res = {mval[0], mval[DW-1:1]};               // [RL18]
          OP_RRC:  res = {c_reg, mval[DW-1:1]};
          OP_RL:   res = {mval[DW-2:0], mval[DW-1]};
          default: res = {mval[DW-2:0], c_reg};
        endcase
        if (opc == OP_RRC) begin
          c_n = mval[0];
        end
        if (opc == OP_RLC) begin
          c_n = mval[DW-1];
        end
        wr_acc = !to_mem;
        wr_mem = to_mem;
      end
      OP_INC, OP_DEC, OP_SIZ, OP_SDZ: begin
        res    = (opc == OP_INC || opc == OP_SIZ) ? mval + 8'h01 : mval - 8'h01; // [RL19]
        upd_z  = (opc == OP_INC || opc == OP_DEC);
        skip   = (opc == OP_SIZ || opc == OP_SDZ) && (res == '0);          // [RL20]
        wr_acc = !to_mem;
        wr_mem = to_mem;
      end
      OP_SZ:   skip = (mval == '0);                             // [RL20]
      OP_SNZ:  skip = (mval != '0);
      OP_MOV: begin
        res    = to_mem ? acc_reg : mval;
        wr_acc = !to_mem;
        wr_mem = to_mem;
      end
      OP_MOVI: begin
        res    = imm;
        wr_acc = 1'b1;
      end
      default: ;
    endcase
  end

  wire is_jump   = (opc == OP_JMP) || (opc == OP_CALL);
  wire is_ret    = (opc == OP_RET) || (opc == OP_RETURN_FROM_INTERRUPT);
  wire pc_low_wr = wr_mem && (ma == MA_PC_LOW);
  wire flush_ins = is_jump || is_ret || skip || pc_low_wr;
  // a withheld request on a full stack waits for a return to pop a level
  wire int_go    = ex_go && pend_reg && ie_reg && !full && !flush_ins; // [RL13]
  wire do_push   = ex_go && (opc == OP_CALL || int_go);
  wire do_pop    = ex_go && is_ret;
  wire flush_any = flush_ins || int_go;

  //////////////////////////////////////////////////////////////////////////
  // phase sequencer; a stopped core rests in phase one
  always_comb begin
    case (phase_reg)
      PH_T1:   phase_next = run_reg ? PH_T2 : PH_T1;            // [RL1]
      PH_T2:   phase_next = PH_T3;
      PH_T3:   phase_next = PH_T4;
      PH_T4:   phase_next = PH_T1;
      default: phase_next = PH_T1;
    endcase
  end

  always_comb begin
    pc_next = pc_reg;
    if (run_reg && phase_reg == PH_T1) begin
      pc_next = pc_reg + PC_ONE;                                // [RL2] [RL6]
    end else if (int_go) begin
      pc_next = INT_VEC;                                        // [RL8]
    end else if (ex_go && is_jump) begin
      pc_next = jtgt;                                           // [RL8]
    end else if (do_pop) begin
      pc_next = stk_top;                                        // [RL11]
    end else if (ex_go && pc_low_wr) begin
      pc_next = {pmem_addr_reg[PC_W-1:PAGE_LSB], res};          // [RL9]
    end
  end

  // pointer never exceeds full; an overflowing call wraps the slot index
  always_comb begin
    sp_next = sp_reg;
    if (do_push && !full) begin
      sp_next = sp_reg + SP_ONE;                                // [RL11]
    end else if (do_pop && sp_reg != '0) begin
      sp_next = sp_reg - SP_ONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg     <= PH_T1;
      pc_reg        <= RESET_VEC;                               // [RL8]
      sp_reg        <= '0;                                      // [RL12]
      pmem_addr_reg <= RESET_VEC;
    end else begin
      phase_reg <= phase_next;
      pc_reg    <= pc_next;
      sp_reg    <= sp_next;
      if (run_reg && phase_reg == PH_T1) begin
        pmem_addr_reg <= pc_reg;                                // [RL2]
      end
    end
  end

  // memory answers one edge after the address; sampled at the end of phase three
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_reg <= NOP_WORD;
      ir_reg    <= NOP_WORD;
    end else begin
      if (phase_reg == PH_T3) begin
        fetch_reg <= pmem_data;                                 // [RL3]
      end
      if (ex_go) begin
        ir_reg <= flush_any ? NOP_WORD : fetch_reg;             // [RL4] [RL5]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= '0;
      c_reg   <= 1'b0;
      z_reg   <= 1'b0;
      ac_reg  <= 1'b0;
    end else if (ex_go) begin
      if (wr_acc) begin
        acc_reg <= res;                                         // [RL21]
      end
      c_reg  <= c_n;                                            // [RL15]
      ac_reg <= ac_n;
      if (upd_z) begin
        z_reg <= (res == '0);
      end
    end
  end

  generate
    // slot zero aliases the counter low byte, so it is never written
    for (genvar i = 0; i < DMEM_N; i++) begin : g_dmem
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          dmem_reg[i] <= '0;
        end else if (ex_go && wr_mem && !pc_low_wr && ma == DMEM_AW'(i)) begin
          dmem_reg[i] <= res;                                   // [RL15]
        end
      end
    end
    // stack is reachable only by push and pop, never by software
    for (genvar s = 0; s < STACK_DEPTH; s++) begin : g_stack
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          stack_reg[s] <= '0;
        end else if (do_push && push_ix == SI_W'(s)) begin
          stack_reg[s] <= pmem_addr_reg;                        // [RL10] [RL14]
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // bus slave, zero wait states
  wire       ap_take = hsel && htrans[1] && hready;
  wire [1:0] ap_idx  = haddr[3:2];
  wire       ap_map  = (haddr[7:4] == '0);
  wire       wr_dp   = ap_valid_reg && ap_wr_reg;
  wire       sw_set  = wr_dp && (ap_idx_reg == REG_PEND) && hwdata[0];
  wire       sw_ctrl = wr_dp && (ap_idx_reg == REG_CTRL);
  wire [31:0] state_word = {13'h0000, ac_reg, z_reg, c_reg, full,
                            SI_W'(0) | 3'(sp_reg), pc_reg};
  wire [31:0] rd_mux =
      !ap_map               ? 32'h0000_0000 :
      (ap_idx == REG_CTRL)  ? {30'h0, ie_reg, run_reg} :
      (ap_idx == REG_PEND)  ? {31'h0, pend_reg} :
      (ap_idx == REG_STATE) ? state_word : {24'h000000, acc_reg};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg  <= 1'b0;
      ap_wr_reg     <= 1'b0;
      ap_idx_reg    <= '0;
      hrdata_reg    <= '0;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      ap_valid_reg  <= ap_take && ap_map;
      ap_wr_reg     <= hwrite;
      ap_idx_reg    <= ap_idx;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      if (ap_take && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // request flag: a new request wins over the acknowledge clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg  <= CTRL_RESET[CTRL_RUN];
      ie_reg   <= CTRL_RESET[CTRL_IE];
      pend_reg <= 1'b0;
      ack_reg  <= 1'b0;
    end else begin
      ack_reg <= int_go;
      if (irq_req || sw_set) begin
        pend_reg <= 1'b1;                                       // [RL13]
      end else if (int_go) begin
        pend_reg <= 1'b0;
      end
      if (sw_ctrl) begin
        run_reg <= hwdata[CTRL_RUN];
        ie_reg  <= hwdata[CTRL_IE];
      end else if (int_go) begin
        ie_reg <= 1'b0;
      end else if (ex_go && opc == OP_RETURN_FROM_INTERRUPT) begin
        ie_reg <= 1'b1;
      end
    end
  end

  assign hrdata      = hrdata_reg;
  assign hreadyout   = hreadyout_reg;
  assign hresp       = hresp_reg;
  assign pmem_addr   = pmem_addr_reg;
  assign int_ack     = ack_reg;
  assign cycle_start = phase_reg[0];                            // one-hot bit of phase one

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_phase_onehot: assert property ($onehot(phase_reg)) // [RL1]
    else $error("phase not one-hot");
  a_phase_walk: assert property (run_reg && phase_reg == PH_T1 |=> // [RL1]
      phase_reg == PH_T2 ##1 phase_reg == PH_T3 ##1 phase_reg == PH_T4)
    else $error("phase order broken");
  a_fetch_incr: assert property (run_reg && phase_reg == PH_T1 |=> // [RL2]
      pmem_addr_reg == $past(pc_reg) && pc_reg == $past(pc_reg) + PC_ONE)
    else $error("fetch did not advance counter");
  a_pipe_feed: assert property (ex_go && !flush_any |=> ir_reg == $past(fetch_reg)) // [RL3]
    else $error("prefetched word not executed");
  a_jump_flush: assert property (ex_go && is_jump && !int_go |=> // [RL4]
      ir_reg == NOP_WORD && pc_reg == $past(jtgt))
    else $error("jump did not flush to target");
  a_skip_dummy: assert property (ex_go && skip |=> ir_reg == NOP_WORD) // [RL5]
    else $error("taken skip kept prefetch");
  a_pc_low_page: assert property (ex_go && pc_low_wr |=> // [RL9]
      pc_reg[PC_W-1:PAGE_LSB] == $past(pmem_addr_reg[PC_W-1:PAGE_LSB]) &&
      ir_reg == NOP_WORD)
    else $error("low byte write left page");
  a_call_push: assert property (ex_go && opc == OP_CALL && !full |=> // [RL11]
      sp_reg == $past(sp_reg) + SP_ONE && stack_reg[$past(push_ix)] == $past(pmem_addr_reg))
    else $error("call did not push");
  a_full_hold: assert property (ex_go && full && pend_reg && !is_ret |=> full && !ack_reg) // [RL13]
    else $error("acknowledge on full stack");
  a_sp_bound: assert property (sp_reg <= SP_FULL) // [RL22]
    else $error("stack pointer past depth");

  c_call: cover property (ex_go && opc == OP_CALL);
  c_int_ack: cover property (int_go);
  c_skip: cover property (ex_go && skip);
  c_full_wait: cover property (full && pend_reg && ie_reg ##[1:40] int_go);

endmodule

// ===== sim/mps_pmem_model.sv
`timescale 1ns/1ps
module mps_pmem_model (
  input  wire logic                     clk,
  input  wire logic [mps_pkg::PC_W-1:0] addr,
  output      logic [mps_pkg::IW-1:0]   data
);
  import mps_pkg::*;
  logic [IW-1:0]   mem [1<<PC_W];
  logic [PC_W-1:0] addr_q;
  logic [IW-1:0]   last;
  always @(posedge clk) begin
    addr_q <= addr;
    last   <= data;
  end
  // word still settling in the cycle after an address change: junk, not the old word
  assign data = (addr == addr_q) ? mem[addr] : ~last;
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end
module tb_top;
  import mps_pkg::*;
  localparam int TMO = 3000;
  // {address, word}: MOVI 5, MOV m1, ADD, CALL 10, SNZ, MOV m0, ADD, MOV m0, JMP, RET, CALL
  localparam logic [31:0] PROG [11] = '{32'h0000_C805, 32'h0001_C401, 32'h0002_0801,
    32'h0003_A810, 32'h0004_8801, 32'h0005_C400, 32'h0006_0801, 32'h0007_C400,
    32'h000F_A00F, 32'h0010_B000, 32'h0014_A814};
  localparam logic [11:0] TRACE [16] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004,
    12'h010, 12'h011, 12'h004, 12'h005, 12'h006, 12'h007, 12'h008, 12'h00F, 12'h010,
    12'h00F, 12'h010};
  logic            hclk;
  logic            hresetn;
  logic            hsel;
  logic [31:0]     haddr;
  logic [1:0]      htrans;
  logic            hwrite;
  logic [2:0]      hsize;
  logic [31:0]     hwdata;
  logic            hready;
  logic [31:0]     hrdata;
  logic            hreadyout;
  logic            hresp;
  logic [PC_W-1:0] pmem_addr;
  logic [IW-1:0]   pmem_data;
  logic            irq_req;
  logic            int_ack;
  logic            cycle_start;
  logic            rd_dp;
  logic            prev_cs;
  logic [31:0]     ev;
  logic [31:0]     mv;
  logic [31:0]     rnd;
  logic [PC_W-1:0] fa;
  logic [31:0]     exp_q[$];
  logic [31:0]     msk_q[$];
  logic [PC_W-1:0] fq[$];
  int              errors;
  int              cmp_count;
  int              cyc;
  int              ack_cnt;
  int              n;
  integer          seed;

  assign hready = hreadyout;
  mps_core #(.STACK_DEPTH(2)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pmem_addr(pmem_addr), .pmem_data(pmem_data), .irq_req(irq_req), .int_ack(int_ack),
    .cycle_start(cycle_start));
  mps_pmem_model pmem (.clk(hclk), .addr(pmem_addr), .data(pmem_data));

  initial hclk = 1'b0;
  always #12.5 hclk = ~hclk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] ra(input logic [1:0] r);
    return {28'h0, r, 2'b00};
  endfunction

  // reads note d (masked) as the expected data; writes put d on hwdata
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    if (!wr) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (wr) hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  task automatic irq_pulse();
    irq_req <= 1'b1;
    @(posedge hclk);
    irq_req <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    if (rd_dp && hready && exp_q.size() > 0) begin
      ev = exp_q.pop_front();
      mv = msk_q.pop_front();
      `CHK(({hresp, hrdata & mv}), ({1'b0, ev}))
    end
    // fetch address settles in T2, so look one edge after T1 ends
    if (prev_cs && !cycle_start && fq.size() > 0) begin
      fa = fq.pop_front();
      `CHK(pmem_addr, fa)
    end
    if (int_ack === 1'b1) ack_cnt++;
    rd_dp <= hsel & htrans[1] & !hwrite & hready;
    prev_cs <= cycle_start;
    cyc++;
    if (cyc == TMO) begin
      errors++;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hD0281278;
    {hresetn, hsel, hwrite, irq_req, rd_dp, prev_cs} = 6'h00;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    ack_cnt = 0;
    for (int i = 0; i < (1 << PC_W); i++) pmem.mem[i] = NOP_WORD;
    foreach (PROG[i]) pmem.mem[PROG[i][16+:PC_W]] = PROG[i][IW-1:0];
    foreach (TRACE[i]) fq.push_back(TRACE[i]);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, ra(REG_CTRL), CTRL_RESET, 32'hFFFF_FFFF);
    ahb(1'b0, ra(REG_STATE), 32'h0, 32'h0000_F000);
    rnd = $random(seed);
    ahb(1'b1, 32'h0000_0040, rnd, 32'h0);
    ahb(1'b0, 32'h0000_0040, 32'h0, 32'hFFFF_FFFF);
    rnd = $random(seed);
    ahb(1'b1, ra(REG_PEND), rnd & 32'hFFFF_FFFE, 32'h0);
    ahb(1'b0, ra(REG_PEND), 32'h0, 32'h1);
    n = 0;
    while (fq.size() > 0 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    `CHK(fq.size(), 0)
    ahb(1'b0, ra(REG_ACC), 32'h0F, 32'hFF);
    ahb(1'b0, ra(REG_STATE), 32'h0, 32'h0003_F000);
    $display("test fetch trace done");

    ahb(1'b1, ra(REG_CTRL), 32'h3, 32'h0);
    irq_pulse();
    n = 0;
    while (pmem_addr !== 12'h014 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    `CHK(ack_cnt, 1)
    // let the self-call at the handler fill the two-level stack and run past it
    repeat (32) @(posedge hclk);
    ahb(1'b0, ra(REG_ACC), 32'h14, 32'hFF);
    ahb(1'b0, ra(REG_CTRL), 32'h1, 32'h3);
    ahb(1'b0, ra(REG_STATE), 32'h0000_A000, 32'h0000_F000);
    $display("test interrupt and overflow done");

    ahb(1'b1, ra(REG_CTRL), 32'h3, 32'h0);
    irq_pulse();
    repeat (40) @(posedge hclk);
    `CHK(ack_cnt, 1)
    ahb(1'b0, ra(REG_PEND), 32'h1, 32'h1);
    ahb(1'b0, ra(REG_CTRL), 32'h3, 32'h3);
    $display("test full stack inhibit done");
    give_verdict();
  end
endmodule
